// ### hdl/gpio_level_pwm_encoder.sv
// pwm encoder of the logic level of one shared output pin, with registers
// assumes axi4-lite master on mclk_in and a synchronous pin level input
`timescale 1ns/1ps
module gpio_level_pwm_encoder #(
    parameter int ADDR_W = 12,
    parameter int CNT_W = pwm_pkg::CNT_W
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic pin_level_in,
    input wire logic pin_output_mode_in,
    output logic shared_output_pin_out,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    if (CNT_W != pwm_pkg::CNT_W)
    begin : g_bad_cnt_w
        $error("counter width must match register fields");
    end
    if (ADDR_W < 9)
    begin : g_bad_addr_w
        $error("address width too small for register map");
    end

    // byte address to register decode
    function automatic pwm_pkg::reg_sel_t decode(
        input logic [ADDR_W-1:0] addr
    );
        logic [ADDR_W-1:0] a;
        a = addr;
        if (a[pwm_pkg::BYTE_SHIFT-1:0] != '0)
            decode = pwm_pkg::REG_NONE;
        else if (a[ADDR_W-1:pwm_pkg::BYTE_SHIFT] ==
                 (ADDR_W-pwm_pkg::BYTE_SHIFT)'(pwm_pkg::LOW_CFG_IDX))
            decode = pwm_pkg::REG_LOW;
        else if (a[ADDR_W-1:pwm_pkg::BYTE_SHIFT] ==
                 (ADDR_W-pwm_pkg::BYTE_SHIFT)'(pwm_pkg::HIGH_CFG_IDX))
            decode = pwm_pkg::REG_HIGH;
        else if (a[ADDR_W-1:pwm_pkg::BYTE_SHIFT] ==
                 (ADDR_W-pwm_pkg::BYTE_SHIFT)'(pwm_pkg::STATUS_IDX))
            decode = pwm_pkg::REG_STATUS;
        else
            decode = pwm_pkg::REG_NONE;
    endfunction : decode

    // axi write side
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic do_write;
    pwm_pkg::reg_sel_t wr_sel;

    assign s_axi_awready_out = !aw_have_q && !bvalid_q;
    assign s_axi_wready_out = !w_have_q && !bvalid_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign wr_sel = decode(aw_addr_q);

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
        end
        else if (s_axi_awvalid_in && s_axi_awready_out)
        begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_in;
        end
        else if (do_write)
            aw_have_q <= 1'b0;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end
        else if (s_axi_wvalid_in && s_axi_wready_out)
        begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
        end
        else if (do_write)
            w_have_q <= 1'b0;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= pwm_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_q <= 1'b1;
            if (wr_sel == pwm_pkg::REG_LOW || wr_sel == pwm_pkg::REG_HIGH)
                bresp_q <= pwm_pkg::RESP_OKAY;
            else
                bresp_q <= pwm_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready_in)
            bvalid_q <= 1'b0;
    end

    // configuration registers, one generate lane per byte
    logic [pwm_pkg::CFG_W-1:0] low_cfg_q;
    logic [pwm_pkg::CFG_W-1:0] high_cfg_q;

    for (genvar b = 0; b < 2; b++)
    begin : g_lane
        always_ff @(posedge mclk_in)
        begin
            if (!rst_n_in)
            begin
                low_cfg_q[b*8 +: 8] <= pwm_pkg::LOW_CFG_RST[b*8 +: 8];
                high_cfg_q[b*8 +: 8] <= pwm_pkg::HIGH_CFG_RST[b*8 +: 8];
            end
            else if (do_write && w_strb_q[b])
            begin
                if (wr_sel == pwm_pkg::REG_LOW)
                    low_cfg_q[b*8 +: 8] <= w_data_q[b*8 +: 8]
                        & pwm_pkg::LOW_CFG_MASK[b*8 +: 8];
                if (wr_sel == pwm_pkg::REG_HIGH)
                    high_cfg_q[b*8 +: 8] <= w_data_q[b*8 +: 8]
                        & pwm_pkg::HIGH_CFG_MASK[b*8 +: 8];
            end
        end
    end

    logic [pwm_pkg::TB_W-1:0] tb_sel;
    logic [CNT_W-1:0] ll_hc;
    logic [CNT_W-1:0] ll_lc;
    logic [CNT_W-1:0] lh_hc;
    logic [CNT_W-1:0] lh_lc;

    assign tb_sel = low_cfg_q[pwm_pkg::TB_LSB +: pwm_pkg::TB_W];
    assign ll_hc = low_cfg_q[pwm_pkg::HC_LSB +: CNT_W];
    assign ll_lc = low_cfg_q[pwm_pkg::LC_LSB +: CNT_W];
    assign lh_hc = high_cfg_q[pwm_pkg::HC_LSB +: CNT_W];
    assign lh_lc = high_cfg_q[pwm_pkg::LC_LSB +: CNT_W];

    // encoder
    logic tick;
    pwm_pkg::enc_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] lc_act_q;
    logic level_act_q;
    logic out_q;
    logic [CNT_W-1:0] sel_hc;
    logic [CNT_W-1:0] sel_lc;
    logic period_end;

    pwm_time_base u_time_base (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .enable_in(pin_output_mode_in),
        .sel_in(tb_sel),
        .tick_out(tick)
    );

    // pair chosen by the pin level at a period boundary
    always_comb
    begin
        if (pin_level_in)
        begin
            sel_hc = lh_hc;
            sel_lc = lh_lc;
        end
        else
        begin
            sel_hc = ll_hc;
            sel_lc = ll_lc;
        end
    end

    always_comb
    begin
        case (state_q)
            pwm_pkg::ST_IDLE: period_end = 1'b1;
            pwm_pkg::ST_STATIC: period_end = 1'b1;
            pwm_pkg::ST_LOW: period_end = (cnt_q == '0);
            default: period_end = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= pwm_pkg::ST_IDLE;
            cnt_q <= '0;
            lc_act_q <= '0;
            level_act_q <= 1'b0;
            out_q <= 1'b0;
        end
        else if (!pin_output_mode_in)
        begin
            state_q <= pwm_pkg::ST_IDLE;
            cnt_q <= '0;
            out_q <= 1'b0;
        end
        else if (tick)
        begin
            if (period_end)
            begin
                level_act_q <= pin_level_in;
                lc_act_q <= sel_lc;
                cnt_q <= sel_hc - 1'b1;
                if (sel_hc == '0)
                begin
                    state_q <= pwm_pkg::ST_STATIC;
                    out_q <= 1'b0;
                end
                else if (sel_lc == '0)
                begin
                    state_q <= pwm_pkg::ST_STATIC;
                    out_q <= 1'b1;
                end
                else
                begin
                    state_q <= pwm_pkg::ST_HIGH;
                    out_q <= 1'b1;
                end
            end
            else if (state_q == pwm_pkg::ST_HIGH)
            begin
                if (cnt_q == '0)
                begin
                    state_q <= pwm_pkg::ST_LOW;
                    out_q <= 1'b0;
                    cnt_q <= lc_act_q - 1'b1;
                end
                else
                    cnt_q <= cnt_q - 1'b1;
            end
            else
                cnt_q <= cnt_q - 1'b1;
        end
    end

    assign shared_output_pin_out = out_q;

    // axi read side
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    pwm_pkg::reg_sel_t rd_sel;

    assign rd_sel = decode(s_axi_araddr_in);
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= pwm_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid_in && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= pwm_pkg::RESP_OKAY;
            case (rd_sel)
                pwm_pkg::REG_LOW: rdata_q <= {16'h0000, low_cfg_q};
                pwm_pkg::REG_HIGH: rdata_q <= {16'h0000, high_cfg_q};
                pwm_pkg::REG_STATUS:
                    rdata_q <= {27'h0000000, level_act_q, out_q,
                                tick, state_q};
                default:
                begin
                    rdata_q <= '0;
                    rresp_q <= pwm_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready_in)
            rvalid_q <= 1'b0;
    end
endmodule : gpio_level_pwm_encoder

// ### hdl/pwm_pkg.sv
// constants of the level-driven pwm encoder for one shared output pin
// assumes a 100 MHz master clock and an axi4-lite register port
// What this block does
// - time base 16, 64, 256 or 1024 master clocks
// - time base drives encoder while pin outputs
// - period equals high plus low counts
// - high time equals high count times base
// - low time equals low count times base
// - low count zero with a nonzero high count holds output high
// - high count zero holds output low
// - both counts zero hold output low
// - low pin level uses low-level counter pair
// - high pin level uses high-level counter pair
package pwm_pkg;
    localparam int CNT_W = 7;
    localparam int TB_W = 2;
    localparam int TB_CNT_W = 10;
    // printed register indices; byte address is four times the index
    localparam logic [7:0] LOW_CFG_IDX = 8'h57;
    localparam logic [7:0] HIGH_CFG_IDX = 8'h58;
    localparam logic [7:0] STATUS_IDX = 8'h5C;
    localparam int BYTE_SHIFT = 2;
    localparam logic [15:0] LOW_CFG_RST = 16'h007F;
    localparam logic [15:0] HIGH_CFG_RST = 16'h3F80;
    localparam int LC_LSB = 0;
    localparam int HC_LSB = 7;
    localparam int TB_LSB = 14;
    localparam int CFG_W = 16;
    localparam logic [15:0] HIGH_CFG_MASK = 16'h3FFF;
    localparam logic [15:0] LOW_CFG_MASK = 16'hFFFF;
    // time base divisions in master clock periods
    localparam logic [TB_W-1:0] TB_SEL_16 = 2'h0;
    localparam logic [TB_W-1:0] TB_SEL_64 = 2'h1;
    localparam logic [TB_W-1:0] TB_SEL_256 = 2'h2;
    localparam logic [TB_W-1:0] TB_SEL_1024 = 2'h3;
    localparam logic [TB_CNT_W-1:0] TB_LAST_16 = 10'h00F;
    localparam logic [TB_CNT_W-1:0] TB_LAST_64 = 10'h03F;
    localparam logic [TB_CNT_W-1:0] TB_LAST_256 = 10'h0FF;
    localparam logic [TB_CNT_W-1:0] TB_LAST_1024 = 10'h3FF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HIGH = 2'b01,
        ST_LOW = 2'b10,
        ST_STATIC = 2'b11
    } enc_state_t;

    typedef enum logic [1:0] {
        REG_NONE = 2'b00,
        REG_LOW = 2'b01,
        REG_HIGH = 2'b10,
        REG_STATUS = 2'b11
    } reg_sel_t;

    // last count value of the time base divider for a selector code
    function automatic logic [TB_CNT_W-1:0] tb_last(
        input logic [TB_W-1:0] sel
    );
        case (sel)
            TB_SEL_16: tb_last = TB_LAST_16;
            TB_SEL_64: tb_last = TB_LAST_64;
            TB_SEL_256: tb_last = TB_LAST_256;
            default: tb_last = TB_LAST_1024;
        endcase
    endfunction : tb_last
endpackage : pwm_pkg

// ### hdl/pwm_time_base.sv
// divider giving one tick per selected time base
// assumes enable_in low clears it so the first tick is one base away
`timescale 1ns/1ps
module pwm_time_base (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic [pwm_pkg::TB_W-1:0] sel_in,
    output logic tick_out
);
    logic [pwm_pkg::TB_CNT_W-1:0] cnt_q;
    logic [pwm_pkg::TB_W-1:0] sel_q;
    logic wrap;

    assign wrap = (cnt_q >= pwm_pkg::tb_last(sel_in));
    assign tick_out = enable_in && wrap;

    // restart the base when the selector changes
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q <= '0;
            sel_q <= pwm_pkg::TB_SEL_16;
        end
        else
        begin
            sel_q <= sel_in;
            if (!enable_in || wrap || sel_q != sel_in)
                cnt_q <= '0;
            else
                cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : pwm_time_base

// ### verification/pwm_enc_sva.sv
// assertions on the ports of the pwm encoder
// assumes binding to gpio_level_pwm_encoder
`timescale 1ns/1ps
module pwm_enc_sva (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic pin_output_mode_in,
    input wire logic shared_output_pin_out,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_wr_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
            && s_axi_wready_out;
    endsequence
    sequence s_out_hold;
        $stable(shared_output_pin_out) [*8];
    endsequence
    property p_rst;
        disable iff (1'b0) !rst_n_in |=> !shared_output_pin_out
            && !s_axi_bvalid_out && !s_axi_rvalid_out;
    endproperty
    property p_idle;
        !pin_output_mode_in |=> !shared_output_pin_out;
    endproperty
    property p_hi_min;
        disable iff (!rst_n_in || !pin_output_mode_in)
            $rose(shared_output_pin_out) |=> s_out_hold;
    endproperty
    property p_lo_min;
        disable iff (!rst_n_in || !pin_output_mode_in)
            $fell(shared_output_pin_out) |=> s_out_hold;
    endproperty
    property p_wr;
        s_wr_taken |-> ##[1:2] s_axi_bvalid_out;
    endproperty
    property p_rd;
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
    endproperty
    property p_b_hold;
        s_axi_bvalid_out && !s_axi_bready_in |=>
            s_axi_bvalid_out && $stable(s_axi_bresp_out);
    endproperty
    property p_r_hold;
        s_axi_rvalid_out && !s_axi_rready_in |=>
            s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    property p_ar_block;
        s_axi_rvalid_out |-> !s_axi_arready_out;
    endproperty
    property p_rsv;
        s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_idle: assert property (p_idle) else $error("idle pin high");
    a_hi_min: assert property (p_hi_min) else $error("high too short");
    a_lo_min: assert property (p_lo_min) else $error("low too short");
    a_wr: assert property (p_wr) else $error("write response late");
    a_rd: assert property (p_rd) else $error("read response late");
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    a_ar_block: assert property (p_ar_block) else $error("arready high");
    a_rsv: assert property (p_rsv) else $error("upper bits set");
endmodule : pwm_enc_sva

bind gpio_level_pwm_encoder pwm_enc_sva u_sva (.mclk_in, .rst_n_in,
    .pin_output_mode_in, .shared_output_pin_out, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rvalid_out, .s_axi_rready_in);

// ### verification/pwm_receiver.sv
// far-side receiver: measures high and low run lengths of the pin
// assumes the pin is sampled on the master clock
`timescale 1ns/1ps
module pwm_receiver (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic line_in,
    output logic [15:0] high_len_out,
    output logic [15:0] low_len_out,
    output logic period_done_out
);
    logic prev_q;
    logic [15:0] cnt_q;

    // a rising edge closes one period and reports the low length; a falling edge reports the high length
    always_ff @(posedge clk_in)
    begin
        prev_q <= line_in;
        period_done_out <= 1'b0;
        if (!rst_n_in)
            cnt_q <= 16'h0000;
        else if (line_in != prev_q)
        begin
            cnt_q <= 16'h0001;
            if (line_in)
            begin
                low_len_out <= cnt_q;
                period_done_out <= 1'b1;
            end
            else
                high_len_out <= cnt_q;
        end
        else
            cnt_q <= cnt_q + 16'h0001;
    end
endmodule : pwm_receiver

// ### verification/tb_top.sv
// self-checking bench of the pwm encoder over axi4-lite
// assumes the pwm_receiver model watches the pin
`timescale 1ns/1ps
module tb_top;
    localparam logic [11:0] A_LO = {2'h0, pwm_pkg::LOW_CFG_IDX, 2'h0};
    localparam logic [11:0] A_HI = {2'h0, pwm_pkg::HIGH_CFG_IDX, 2'h0};
    localparam logic [1:0] OK = pwm_pkg::RESP_OKAY;
    localparam logic [1:0] ER = pwm_pkg::RESP_SLVERR;
    logic mclk_in = 1'b0, rst_n_in = 1'b0;
    logic pin_level_in = 1'b0, pin_output_mode_in = 1'b0;
    logic shared_output_pin_out;
    logic [11:0] s_axi_awaddr_in = 12'h000, s_axi_araddr_in = 12'h000;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
    logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
    logic s_axi_rready_in = 1'b0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [15:0] hi_len, lo_len;
    logic done, armed = 1'b0;
    logic [33:0] rq[$], pq[$];
    logic [1:0] bq[$];
    int error_cnt = 0, checks = 0, seed = 88;
    logic [31:0] r;

    gpio_level_pwm_encoder uut (.mclk_in, .rst_n_in, .pin_level_in,
        .pin_output_mode_in, .shared_output_pin_out, .s_axi_awaddr_in,
        .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
        .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
        .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
        .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
        .s_axi_rready_in);
    pwm_receiver rx (.clk_in(mclk_in), .rst_n_in(rst_n_in),
        .line_in(shared_output_pin_out), .high_len_out(hi_len),
        .low_len_out(lo_len), .period_done_out(done));

    always #5 mclk_in = ~mclk_in;

    task automatic finish_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    task automatic check(input logic [33:0] seen, input logic [33:0] exp,
                         input string what);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        @(posedge mclk_in);
        bq.push_back(e);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'($random(seed));
        do
        begin
            @(posedge mclk_in);
            if (s_axi_awready_out)
                s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out)
                s_axi_wvalid_in <= 1'b0;
            s_axi_bready_in <= !(s_axi_bvalid_out && s_axi_bready_in);
        end while (!(s_axi_bvalid_out && s_axi_bready_in));
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        @(posedge mclk_in);
        rq.push_back(e);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'($random(seed));
        do
        begin
            @(posedge mclk_in);
            if (s_axi_arready_out)
                s_axi_arvalid_in <= 1'b0;
            s_axi_rready_in <= !(s_axi_rvalid_out && s_axi_rready_in);
        end while (!(s_axi_rvalid_out && s_axi_rready_in));
    endtask : rd

    task automatic measure(input logic [33:0] exp);
        pq.push_back(exp);
        armed <= 1'b1;
        do
            @(posedge mclk_in);
        while (armed);
    endtask : measure

    // the unused pair holds swapped counts so a wrong pair shows
    task automatic run(input logic [1:0] sel, input logic lvl,
                       input logic [6:0] hc, input logic [6:0] lc);
        int n;
        n = 16 << (2 * sel);
        pin_output_mode_in <= 1'b0;
        wr(A_LO, {16'h0, sel, lvl ? {lc, hc} : {hc, lc}}, OK);
        wr(A_HI, {18'h0, lvl ? {hc, lc} : {lc, hc}}, OK);
        pin_level_in <= lvl;
        pin_output_mode_in <= 1'b1;
        repeat (2 * n) @(posedge mclk_in);
        measure({2'h0, 16'(hc * n), 16'(lc * n)});
        pin_level_in <= !lvl;
        repeat (2 * (hc + lc) * n) @(posedge mclk_in);
        measure({2'h0, 16'(lc * n), 16'(hc * n)});
    endtask : run

    task automatic stat(input logic [6:0] hc, input logic [6:0] lc,
                        input logic v);
        wr(A_LO, {16'h0, 2'h0, hc, lc}, OK);
        repeat (400) @(posedge mclk_in);
        repeat (8)
        begin
            repeat (13) @(posedge mclk_in);
            check({33'h0, shared_output_pin_out}, {33'h0, v}, "static");
        end
    endtask : stat

    always @(posedge mclk_in)
    begin
        if (s_axi_rvalid_out && s_axi_rready_in)
            check({s_axi_rresp_out, s_axi_rdata_out}, rq.pop_front(), "rd");
        if (s_axi_bvalid_out && s_axi_bready_in)
            check({32'h0, s_axi_bresp_out}, {32'h0, bq.pop_front()}, "bresp");
        if (done && armed)
        begin
            check({2'h0, hi_len, lo_len}, pq.pop_front(), "period");
            armed <= 1'b0;
        end
    end

    initial
    begin
        repeat (60000) @(posedge mclk_in);
        error_cnt++;
        finish_test;
    end

    initial
    begin
        repeat (4) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        rd(A_LO, {OK, 32'h0000007F});
        rd(A_HI, {OK, 32'h00003F80});
        rd(12'h004, {ER, 32'h0});
        rd({2'h0, pwm_pkg::STATUS_IDX, 2'h0}, {OK, 32'h0});
        wr(A_HI, 32'hFFFFFFFF, OK);
        rd(A_HI, {OK, 32'h00003FFF});
        s_axi_wstrb_in <= 4'h1;
        wr(A_HI, 32'h0, OK);
        s_axi_wstrb_in <= 4'hF;
        rd(A_HI, {OK, 32'h00003F00});
        wr(12'h010, 32'h1, ER);
        run(2'h0, 1'b0, 7'h02, 7'h01);
        run(2'h1, 1'b1, 7'h01, 7'h03);
        run(2'h2, 1'b0, 7'h03, 7'h01);
        run(2'h3, 1'b1, 7'h01, 7'h02);
        repeat (3)
        begin
            r = $random(seed);
            run(2'h0, r[14], 7'(r[2:0] | 3'h1), 7'(r[6:4] | 3'h1));
        end
        pin_level_in <= 1'b0;
        stat(7'h05, 7'h00, 1'b1);
        stat(7'h00, 7'h05, 1'b0);
        stat(7'h00, 7'h00, 1'b0);
        finish_test;
    end
endmodule : tb_top
